// >>> src/gfst_pkg.sv
// Shared constants and types for the gyro FIFO and self-test controller.
// Assumes a single 125 MHz clock domain and byte-wide register access.
package gfst_pkg;

    // Register offsets on the 7-bit register address.
    localparam logic [6:0] ADDR_FIFO_STATUS = 7'h0E;
    localparam logic [6:0] ADDR_INT_CTRL = 7'h15;
    localparam logic [6:0] ADDR_IO_MAP = 7'h18;
    localparam logic [6:0] ADDR_WM_ENABLE = 7'h1E;
    localparam logic [6:0] ADDR_EXT_SYNC = 7'h34;
    localparam logic [6:0] ADDR_SELF_TEST = 7'h3C;
    localparam logic [6:0] ADDR_WM_LEVEL = 7'h3D;
    localparam logic [6:0] ADDR_MODE = 7'h3E;
    localparam logic [6:0] ADDR_FIFO_DATA = 7'h3F;

    // Field positions.
    localparam int EXT_SYNC_EN_BIT = 5;
    localparam int EXT_SYNC_SEL_BIT = 4;
    localparam int BIST_TRIG_BIT = 0;
    localparam int BIST_RDY_BIT = 1;
    localparam int BIST_FAIL_BIT = 2;
    localparam int RATE_OK_BIT = 4;
    localparam int INT_CTRL_FIFO_BIT = 6;
    localparam int MAP_FIFO_FIRST_BIT = 2;
    localparam int MAP_FIFO_SECOND_BIT = 5;
    localparam int STATUS_OVERRUN_BIT = 7;

    // Writable masks of the configuration registers.
    localparam logic [7:0] EXT_SYNC_MASK = 8'h30;
    localparam logic [7:0] INT_CTRL_MASK = 8'hC0;
    localparam logic [7:0] IO_MAP_MASK = 8'hA5;
    localparam logic [7:0] WM_LEVEL_MASK = 8'h7F;

    // Values after reset.
    localparam logic [7:0] RST_EXT_SYNC = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_IO_MAP = 8'h00;
    localparam logic [7:0] RST_WM_ENABLE = 8'h08;
    localparam logic [6:0] RST_WM_LEVEL = 7'h00;
    localparam logic [7:0] RST_MODE = 8'h08;

    // Mode codes and the watermark enable code.
    localparam logic [7:0] MODE_FIFO = 8'h40;
    localparam logic [7:0] MODE_STREAM = 8'h80;
    localparam logic [7:0] WM_ENABLE_ON = 8'h88;

    // Buffer geometry.
    localparam int FIFO_DEPTH = 100;
    localparam logic [6:0] FIFO_FULL_FRAMES = 7'd100;
    localparam logic [6:0] STREAM_FULL_FRAMES = 7'd99;
    localparam logic [6:0] LAST_SLOT = 7'd99;
    localparam int FRAME_BYTES = 6;
    localparam logic [2:0] LAST_BYTE = 3'd5;
    localparam logic [7:0] EMPTY_READ_VALUE = 8'h00;

    // Self-test duration.
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIST_TIME_NS = 8000;
    localparam logic [10:0] BIST_CYCLES = 11'(BIST_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [0:0] {
        GFST_BIST_IDLE,
        GFST_BIST_RUN
    } gfst_bist_state_t;

endpackage : gfst_pkg

// >>> src/gfst_bist_if.sv
// Handshake between the register logic and the self-test engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface gfst_bist_if;
    logic trig;
    logic busy;
    logic rdy;
    logic fail;

    modport ctrl (output trig, input busy, input rdy, input fail);
    modport engine (input trig, output busy, output rdy, output fail);
endinterface : gfst_bist_if

// >>> src/gfst_pin_sync.sv
// Three-stage synchroniser for a pin level arriving from outside the clock.
// Assumes the pin is slow compared with the system clock.
`timescale 1ns/1ps
module gfst_pin_sync (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    logic meta;
    logic stage2;
    logic stage3;

    // The output only follows once the last two stages agree, so a single
    // unsettled sample cannot reach the block.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            meta <= i_pin;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3)
            begin
                o_level <= stage3;
            end
        end
    end
endmodule : gfst_pin_sync

// >>> src/gfst_bist.sv
// Built-in self-test sequencer for the rate sensor.
// Assumes the sensor core reports a pass level valid when the run ends.
`timescale 1ns/1ps
module gfst_bist
    import gfst_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_bist_pass,
    gfst_bist_if.engine bist
);
    gfst_bist_state_t state;
    logic [10:0] cycles;
    wire run_done = (state == GFST_BIST_RUN) && (cycles == 11'd1);

    assign bist.busy = (state == GFST_BIST_RUN);

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= GFST_BIST_IDLE;
            cycles <= 11'd0;
            bist.rdy <= 1'b0;
            bist.fail <= 1'b0;
        end
        else
        begin
            case (state)
                GFST_BIST_IDLE:
                begin
                    if (bist.trig)
                    begin
                        state <= GFST_BIST_RUN;
                        cycles <= BIST_CYCLES;
                        bist.rdy <= 1'b0;
                    end
                end
                GFST_BIST_RUN:
                begin
                    cycles <= cycles - 11'd1;
                    if (run_done)
                    begin
                        state <= GFST_BIST_IDLE;
                        bist.rdy <= 1'b1;
                        bist.fail <= ~i_bist_pass;
                    end
                end
                default:
                begin
                    state <= GFST_BIST_IDLE;
                end
            endcase
        end
    end
endmodule : gfst_bist

// >>> src/gfst_ctrl.sv
// Gyro FIFO control, watermark interrupt and self-test register block.
// Assumes the serial front end decodes transfers into byte-wide write and
// read strobes on the system clock and flags the end of each transfer.
`timescale 1ns/1ps
module gfst_ctrl
    import gfst_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [6:0] i_addr,
    input wire logic i_wr_strobe,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd_start,
    input wire logic i_rd_next,
    input wire logic i_xfer_end,
    input wire logic i_frame_valid,
    input wire logic [47:0] i_frame_data,
    input wire logic i_first_interrupt_pin_in,
    input wire logic i_second_interrupt_pin_in,
    input wire logic i_bist_pass,
    input wire logic i_rate_ok,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_first_interrupt_pin,
    output logic o_second_interrupt_pin
);
    function automatic logic [6:0] next_slot(input logic [6:0] slot);
        next_slot = (slot == LAST_SLOT) ? 7'd0 : 7'(slot + 7'd1);
    endfunction : next_slot

    function automatic logic [7:0] frame_byte(input logic [47:0] frame, input logic [2:0] idx);
        frame_byte = frame[8 * idx +: 8];
    endfunction : frame_byte

    // Configuration and status state.
    logic [7:0] ext_sync;
    logic [7:0] int_ctrl;
    logic [7:0] io_map;
    logic [7:0] wm_enable;
    logic [6:0] wm_level;
    logic [7:0] fifo_mode;
    logic overrun;
    logic rate_ok;

    // Buffer state.
    logic [47:0] mem [0:FIFO_DEPTH-1];
    logic [6:0] wr_slot;
    logic [6:0] rd_slot;
    logic [6:0] frame_count;
    logic [2:0] byte_idx;
    logic [6:0] burst_addr;

    // External sync tracking.
    logic first_pin_level;
    logic second_pin_level;
    logic sync_prev;
    logic sync_seen;

    gfst_bist_if bist ();

    gfst_pin_sync u_first_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin(i_first_interrupt_pin_in),
        .o_level(first_pin_level)
    );

    gfst_pin_sync u_second_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin(i_second_interrupt_pin_in),
        .o_level(second_pin_level)
    );

    gfst_bist u_bist (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_bist_pass(i_bist_pass),
        .bist(bist.engine)
    );

    // Write decode.
    wire wr_ext_sync = i_wr_strobe && (i_addr == ADDR_EXT_SYNC);
    wire wr_int_ctrl = i_wr_strobe && (i_addr == ADDR_INT_CTRL);
    wire wr_io_map = i_wr_strobe && (i_addr == ADDR_IO_MAP);
    wire wr_wm_enable = i_wr_strobe && (i_addr == ADDR_WM_ENABLE);
    wire wr_wm_level = i_wr_strobe && (i_addr == ADDR_WM_LEVEL);
    wire wr_mode = i_wr_strobe && (i_addr == ADDR_MODE);
    wire wr_self_test = i_wr_strobe && (i_addr == ADDR_SELF_TEST);

    // A new trigger during a running test is ignored rather than restarting it.
    assign bist.trig = wr_self_test && i_wdata[BIST_TRIG_BIT] && !bist.busy;

    // Buffer flush on watermark level and mode writes.
    wire flush = wr_wm_level || wr_mode;

    // Read addressing: the data port pins the burst address.
    wire rd_access = i_rd_start || i_rd_next;
    wire [6:0] cur_addr = i_rd_start ? i_addr : burst_addr;
    wire [6:0] next_burst_addr = (cur_addr == ADDR_FIFO_DATA) ? cur_addr
                                 : 7'(cur_addr + 7'd1);
    wire rd_fifo = rd_access && (cur_addr == ADDR_FIFO_DATA);

    // Sync source selection and edge detect.
    wire sync_en = ext_sync[EXT_SYNC_EN_BIT];
    wire sync_level = ext_sync[EXT_SYNC_SEL_BIT] ? second_pin_level
                      : first_pin_level;
    wire sync_edge = sync_level && !sync_prev;

    // Occupancy and mode decode.
    wire stream_mode = (fifo_mode == MODE_STREAM);
    wire [6:0] full_frames = stream_mode ? STREAM_FULL_FRAMES : FIFO_FULL_FRAMES;
    wire fifo_full = (frame_count >= full_frames);
    wire fifo_empty = (frame_count == 7'd0);
    wire push_req = i_frame_valid && (!sync_en || sync_seen);
    wire drop_oldest = push_req && fifo_full && stream_mode;
    wire push = push_req && (!fifo_full || stream_mode);
    wire overrun_evt = push_req && fifo_full;

    // Frame consumption: whole frame read, partial frame abandoned, or
    // the oldest frame pushed out in stream mode.
    wire rd_byte = rd_fifo && !fifo_empty;
    wire rd_done = rd_byte && (byte_idx == LAST_BYTE);
    wire rd_abort = i_xfer_end && (byte_idx != 3'd0) && !fifo_empty;
    wire pop = rd_done || rd_abort || drop_oldest;

    wire [6:0] next_count = 7'(frame_count + {6'd0, push} - {6'd0, pop});

    // Watermark interrupt path.
    wire wm_hit = (frame_count > wm_level);
    wire fifo_irq = wm_hit && (wm_enable == WM_ENABLE_ON)
                    && int_ctrl[INT_CTRL_FIFO_BIT];

    // Read data selection.
    wire [7:0] fifo_byte = fifo_empty ? EMPTY_READ_VALUE
                           : frame_byte(mem[rd_slot], byte_idx);
    wire [7:0] self_test_value = {3'd0, rate_ok, 1'b0, bist.fail, bist.rdy, 1'b0};
    wire [7:0] status_value = {overrun, frame_count};
    wire [7:0] rd_mux =
        (cur_addr == ADDR_FIFO_DATA) ? fifo_byte :
        (cur_addr == ADDR_FIFO_STATUS) ? status_value :
        (cur_addr == ADDR_INT_CTRL) ? int_ctrl :
        (cur_addr == ADDR_IO_MAP) ? io_map :
        (cur_addr == ADDR_WM_ENABLE) ? wm_enable :
        (cur_addr == ADDR_EXT_SYNC) ? ext_sync :
        (cur_addr == ADDR_SELF_TEST) ? self_test_value :
        (cur_addr == ADDR_WM_LEVEL) ? {1'b0, wm_level} :
        (cur_addr == ADDR_MODE) ? fifo_mode : 8'h00;

    // Configuration registers.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ext_sync <= RST_EXT_SYNC;
            int_ctrl <= RST_INT_CTRL;
            io_map <= RST_IO_MAP;
            wm_enable <= RST_WM_ENABLE;
            wm_level <= RST_WM_LEVEL;
            fifo_mode <= RST_MODE;
        end
        else
        begin
            if (wr_ext_sync)
            begin
                ext_sync <= i_wdata & EXT_SYNC_MASK;
            end
            if (wr_int_ctrl)
            begin
                int_ctrl <= i_wdata & INT_CTRL_MASK;
            end
            if (wr_io_map)
            begin
                io_map <= i_wdata & IO_MAP_MASK;
            end
            if (wr_wm_enable)
            begin
                wm_enable <= i_wdata;
            end
            if (wr_wm_level)
            begin
                wm_level <= i_wdata[6:0];
            end
            if (wr_mode)
            begin
                fifo_mode <= i_wdata;
            end
        end
    end

    // A frame lost in the same cycle as a mode write still sets the flag, so
    // the host never misses a loss that raced its own reconfiguration.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            overrun <= 1'b0;
        end
        else if (overrun_evt)
        begin
            overrun <= 1'b1;
        end
        else if (wr_mode)
        begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rate_ok <= 1'b0;
        end
        else
        begin
            rate_ok <= i_rate_ok;
        end
    end

    // A new pin edge wins over the clear caused by a stored frame.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync_prev <= 1'b0;
            sync_seen <= 1'b0;
        end
        else
        begin
            sync_prev <= sync_level;
            if (sync_edge)
            begin
                sync_seen <= 1'b1;
            end
            else if (push || !sync_en)
            begin
                sync_seen <= 1'b0;
            end
        end
    end

    // Buffer pointers and occupancy. A flush in the same cycle as an
    // arriving frame wins, so the new configuration starts from empty.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_slot <= 7'd0;
            rd_slot <= 7'd0;
            frame_count <= 7'd0;
            byte_idx <= 3'd0;
        end
        else if (flush)
        begin
            wr_slot <= 7'd0;
            rd_slot <= 7'd0;
            frame_count <= 7'd0;
            byte_idx <= 3'd0;
        end
        else
        begin
            if (push)
            begin
                wr_slot <= next_slot(wr_slot);
            end
            if (pop)
            begin
                rd_slot <= next_slot(rd_slot);
                byte_idx <= 3'd0;
            end
            else if (rd_byte)
            begin
                byte_idx <= 3'(byte_idx + 3'd1);
            end
            frame_count <= next_count;
        end
    end

    // Frame storage has no reset; only slots holding a stored frame are ever read.
    always_ff @(posedge i_sys_clk)
    begin
        if (push && !flush)
        begin
            mem[wr_slot] <= i_frame_data;
        end
    end

    // Register read port.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            burst_addr <= 7'h00;
            o_rdata <= 8'h00;
            o_rdata_valid <= 1'b0;
        end
        else
        begin
            o_rdata_valid <= rd_access;
            if (rd_access)
            begin
                o_rdata <= rd_mux;
                burst_addr <= next_burst_addr;
            end
        end
    end

    // The pins come from flops so that a glitch in the watermark compare
    // never reaches a board line; this costs one cycle of interrupt latency.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_first_interrupt_pin <= 1'b0;
            o_second_interrupt_pin <= 1'b0;
        end
        else
        begin
            o_first_interrupt_pin <= fifo_irq && io_map[MAP_FIFO_FIRST_BIT];
            o_second_interrupt_pin <= fifo_irq && io_map[MAP_FIFO_SECOND_BIT];
        end
    end

endmodule : gfst_ctrl

// >>> verification/gfst_ctrl_checker.sv
// Concurrent checks on the ports of the gyro FIFO and self-test controller.
// Assumes it is bound to every gfst_ctrl instance on the one system clock.
`timescale 1ns/1ps
module gfst_ctrl_checker
    import gfst_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [6:0] i_addr,
    input wire logic i_wr_strobe,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd_start,
    input wire logic i_rd_next,
    input wire logic i_xfer_end,
    input wire logic i_frame_valid,
    input wire logic [47:0] i_frame_data,
    input wire logic i_first_interrupt_pin_in,
    input wire logic i_second_interrupt_pin_in,
    input wire logic i_bist_pass,
    input wire logic i_rate_ok,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic o_first_interrupt_pin,
    input wire logic o_second_interrupt_pin
);
    logic wm_on;
    logic map_first;
    wire rd_any = i_rd_start || i_rd_next;
    wire wr_level = i_wr_strobe && (i_addr == ADDR_WM_LEVEL);
    wire wr_mode = i_wr_strobe && (i_addr == ADDR_MODE);

    // Shadows of the enable registers; the pin may only assert behind both.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wm_on <= 1'b0;
            map_first <= 1'b0;
        end
        else if (i_wr_strobe)
        begin
            if (i_addr == ADDR_WM_ENABLE) wm_on <= (i_wdata == WM_ENABLE_ON);
            if (i_addr == ADDR_IO_MAP) map_first <= i_wdata[MAP_FIFO_FIRST_BIT];
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    chk_rvalid_delay: assert property (rd_any |=> o_rdata_valid)
        else $error("read data valid missing after read strobe");
    chk_rvalid_cause: assert property (o_rdata_valid |-> $past(rd_any))
        else $error("read data valid without read strobe");
    chk_wm_reserved: assert property (
        i_rd_start && i_addr == ADDR_WM_LEVEL |=> !o_rdata[7])
        else $error("watermark reserved bit reads one");
    chk_sync_reserved: assert property (
        i_rd_start && i_addr == ADDR_EXT_SYNC |=> (o_rdata & ~EXT_SYNC_MASK) == 8'h00)
        else $error("sync register reserved bits read one");
    chk_trig_unreadable: assert property (
        i_rd_start && i_addr == ADDR_SELF_TEST |=> !o_rdata[BIST_TRIG_BIT])
        else $error("self-test trigger bit reads back");
    chk_level_flush: assert property (wr_level |-> ##2 !o_first_interrupt_pin)
        else $error("interrupt stays after watermark write");
    chk_mode_flush: assert property (wr_mode |-> ##2 !o_first_interrupt_pin)
        else $error("interrupt stays after mode write");
    chk_wm_enable: assert property (o_first_interrupt_pin |-> $past(wm_on))
        else $error("interrupt without watermark enable code");
    chk_map_first: assert property (o_first_interrupt_pin |-> $past(map_first))
        else $error("first pin asserted while not mapped");
endmodule : gfst_ctrl_checker

bind gfst_ctrl gfst_ctrl_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr_strobe(i_wr_strobe),
    .i_wdata(i_wdata), .i_rd_start(i_rd_start), .i_rd_next(i_rd_next),
    .i_xfer_end(i_xfer_end), .i_frame_valid(i_frame_valid), .i_frame_data(i_frame_data),
    .i_first_interrupt_pin_in(i_first_interrupt_pin_in),
    .i_second_interrupt_pin_in(i_second_interrupt_pin_in), .i_bist_pass(i_bist_pass),
    .i_rate_ok(i_rate_ok), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
    .o_first_interrupt_pin(o_first_interrupt_pin),
    .o_second_interrupt_pin(o_second_interrupt_pin)
);

// >>> verification/gfst_host_model.sv
// Host side of the register access: single byte writes and read bursts.
// Assumes strobes change on the falling clock edge and data is taken there.
`timescale 1ns/1ps
module gfst_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rdata,
    output logic [6:0] o_addr,
    output logic o_wr_strobe,
    output logic [7:0] o_wdata,
    output logic o_rd_start,
    output logic o_rd_next,
    output logic o_xfer_end
);
    initial
    begin
        o_addr = 7'h00;
        o_wr_strobe = 1'b0;
        o_wdata = 8'h00;
        o_rd_start = 1'b0;
        o_rd_next = 1'b0;
        o_xfer_end = 1'b0;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_addr = a;
        o_wdata = d;
        o_wr_strobe = 1'b1;
        @(negedge i_sys_clk);
        o_wr_strobe = 1'b0;
        o_wdata = ~d;
    endtask : wr

    // Reads n bytes (at most six) of one transfer, first byte lowest.
    task automatic rd(input logic [6:0] a, input int n, output logic [47:0] q);
        q = 48'h0;
        @(negedge i_sys_clk);
        o_addr = a;
        o_rd_start = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(negedge i_sys_clk);
            q[8*i +: 8] = i_rdata;
            o_rd_start = 1'b0;
            o_rd_next = (i < n - 1);
        end
        o_xfer_end = 1'b1;
        @(negedge i_sys_clk);
        o_xfer_end = 1'b0;
    endtask : rd
endmodule : gfst_host_model

// >>> verification/tb_gyro_fifo_and_selftest_ctrl.sv
// Self-checking bench for the gyro FIFO and self-test controller.
// Assumes the host model carries register traffic; the bench is the sensor core.
`timescale 1ns/1ps
module tb_gyro_fifo_and_selftest_ctrl
    import gfst_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic frame_valid = 1'b0;
    logic [47:0] frame_data = 48'h0;
    logic pin1 = 1'b0;
    logic pin2 = 1'b0;
    logic bist_pass = 1'b0;
    logic rate_ok = 1'b0;
    logic [6:0] addr;
    logic wr_strobe, rd_start, rd_next, xfer_end, rdata_valid, irq1, irq2;
    logic [7:0] wdata, rdata, d;
    logic [47:0] q;
    logic [47:0] sent [$];
    int seed = 46248;
    int failures = 0;
    int samples_checked = 0;

    always #4 i_sys_clk = ~i_sys_clk;

    gfst_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wr_strobe(wr_strobe), .o_wdata(wdata), .o_rd_start(rd_start),
        .o_rd_next(rd_next), .o_xfer_end(xfer_end));

    gfst_ctrl dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(addr),
        .i_wr_strobe(wr_strobe), .i_wdata(wdata), .i_rd_start(rd_start),
        .i_rd_next(rd_next), .i_xfer_end(xfer_end), .i_frame_valid(frame_valid),
        .i_frame_data(frame_data), .i_first_interrupt_pin_in(pin1),
        .i_second_interrupt_pin_in(pin2), .i_bist_pass(bist_pass), .i_rate_ok(rate_ok),
        .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_first_interrupt_pin(irq1),
        .o_second_interrupt_pin(irq2));

    function automatic logic [47:0] rnd48();
        return 48'({$random(seed), $random(seed)});
    endfunction : rnd48

    function automatic logic [47:0] stat(input logic ov, input int n);
        return 48'({ov, 7'(n)});
    endfunction : stat

    function automatic logic [47:0] bist_exp(input logic pass);
        return 48'({4'b0001, 1'b0, ~pass, 2'b10});
    endfunction : bist_exp

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic push(input logic [47:0] v);
        @(negedge i_sys_clk);
        frame_valid = 1'b1;
        frame_data = v;
        @(negedge i_sys_clk);
        frame_valid = 1'b0;
        frame_data = ~v;
    endtask : push

    task automatic fill(input int n);
        sent.delete();
        repeat (n)
        begin
            sent.push_back(rnd48());
            push(sent[$]);
        end
    endtask : fill

    // The synchroniser needs several edges before a pin level is seen.
    task automatic settle();
        repeat (6) @(negedge i_sys_clk);
    endtask : settle

    task automatic results();
        $display("samples_checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial
    begin
        #200us;
        failures++;
        results();
    end

    initial
    begin
        repeat (10) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        host.rd(ADDR_MODE, 1, q);
        check(q, 48'(RST_MODE));
        host.rd(ADDR_WM_LEVEL, 1, q);
        check(q, 48'h0);
        host.rd(ADDR_EXT_SYNC, 1, q);
        check(q, 48'h0);
        host.rd(ADDR_SELF_TEST, 1, q);
        check(q, 48'h0);
        host.rd(7'h00, 1, q);
        check(q, 48'h0);
        d = 8'($random(seed));
        host.wr(ADDR_EXT_SYNC, d);
        host.rd(ADDR_EXT_SYNC, 1, q);
        check(q, 48'(d & EXT_SYNC_MASK));
        host.wr(ADDR_EXT_SYNC, 8'h00);
        d = 8'($random(seed));
        host.wr(ADDR_WM_LEVEL, d);
        host.rd(ADDR_WM_LEVEL, 1, q);
        check(q, 48'(d & WM_LEVEL_MASK));
        host.wr(ADDR_MODE, MODE_FIFO);
        fill(105);
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b1, 100));
        host.rd(ADDR_FIFO_DATA, 6, q);
        check(q, sent[0]);
        host.rd(ADDR_FIFO_DATA, 2, q);
        host.rd(ADDR_FIFO_DATA, 6, q);
        check(q, sent[2]);
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b1, 97));
        host.wr(ADDR_MODE, MODE_STREAM);
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b0, 0));
        fill(102);
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b1, 99));
        host.rd(ADDR_FIFO_DATA, 6, q);
        check(q, sent[3]);
        host.wr(ADDR_WM_ENABLE, WM_ENABLE_ON);
        host.wr(ADDR_INT_CTRL, 8'h40);
        host.wr(ADDR_IO_MAP, 8'h04);
        host.wr(ADDR_WM_LEVEL, 8'h03);
        fill(3);
        @(negedge i_sys_clk);
        check(48'(irq1), 48'h0);
        push(rnd48());
        @(negedge i_sys_clk);
        check(48'({irq2, irq1}), 48'h1);
        host.wr(ADDR_IO_MAP, 8'h20);
        @(negedge i_sys_clk);
        check(48'({irq2, irq1}), 48'h2);
        host.wr(ADDR_IO_MAP, 8'h04);
        host.wr(ADDR_WM_ENABLE, 8'h08);
        @(negedge i_sys_clk);
        check(48'(irq1), 48'h0);
        host.wr(ADDR_WM_ENABLE, WM_ENABLE_ON);
        @(negedge i_sys_clk);
        check(48'(irq1), 48'h1);
        host.wr(ADDR_WM_LEVEL, 8'h03);
        @(negedge i_sys_clk);
        check(48'(irq1), 48'h0);
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b1, 0));
        host.wr(ADDR_MODE, MODE_STREAM);
        host.wr(ADDR_EXT_SYNC, 8'h20);
        push(rnd48());
        pin1 = 1'b1;
        settle();
        push(rnd48());
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b0, 1));
        host.wr(ADDR_EXT_SYNC, 8'h30);
        pin1 = 1'b0;
        settle();
        pin1 = 1'b1;
        settle();
        push(rnd48());
        pin2 = 1'b1;
        settle();
        push(rnd48());
        host.rd(ADDR_FIFO_STATUS, 1, q);
        check(q, stat(1'b0, 2));
        host.wr(ADDR_EXT_SYNC, 8'h00);
        rate_ok = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            bist_pass = k[0];
            host.wr(ADDR_SELF_TEST, 8'h01);
            host.rd(ADDR_SELF_TEST, 1, q);
            check(q & 48'h12, 48'h10);
            repeat (BIST_CYCLES + 10) @(negedge i_sys_clk);
            host.rd(ADDR_SELF_TEST, 1, q);
            check(q, bist_exp(bist_pass));
        end
        results();
    end
endmodule : tb_gyro_fifo_and_selftest_ctrl
